// file: codec_cfg_pkg.sv
package codec_cfg_pkg;

  // ==========================================================
  // Register map
  localparam logic [6:0]  PAGE_AUDIO       = 7'h02;
  localparam logic [5:0]  ADDR_PATH_CTRL   = 6'h00;
  localparam logic [5:0]  ADDR_RECORD_GAIN = 6'h01;

  // ==========================================================
  // Reset values
  localparam logic [15:0] PATH_CTRL_RESET   = 16'hC003;
  localparam logic [15:0] RECORD_GAIN_RESET = 16'hD7D7;

  // ==========================================================
  // Field positions
  localparam int HIPASS_LSB = 14;
  localparam int LSRC_LSB = 12;
  localparam int RSRC_LSB = 10;
  localparam int MIC_GAIN_LSB = 8;
  localparam int MCLK_LSB = 6;
  localparam int RATE_LSB = 2;
  localparam int FMT_LSB  = 0;
  localparam int LMUTE_BIT = 15;
  localparam int LGAIN_LSB = 8;
  localparam int RMUTE_BIT = 7;
  localparam int RGAIN_LSB = 0;

  // ==========================================================
  // Gain codes
  localparam logic [6:0] GAIN_MAX   = 7'h7F;
  localparam logic [6:0] GAIN_UNITY = 7'h57;
  localparam logic [6:0] GAIN_FLOOR = 7'h07;

  // ==========================================================
  // Encodings
  localparam logic [1:0] MIC_GAIN_0DB_A = 2'h0;
  localparam logic [1:0] MIC_GAIN_0DB_B = 2'h1;
  localparam logic [1:0] MIC_GAIN_6DB   = 2'h2;
  localparam logic [1:0] MIC_GAIN_12DB  = 2'h3;
  localparam logic [1:0] MCLK_384   = 2'h1;
  localparam logic [1:0] MCLK_512   = 2'h2;
  localparam logic [3:0] RATE_LAST  = 4'h8;
  localparam logic [1:0] FMT_16_RJ  = 2'h0;
  localparam logic [1:0] FMT_20_RJ  = 2'h1;
  localparam logic [1:0] FMT_20_LJ  = 2'h2;
  localparam logic [1:0] FMT_20_I2S = 2'h3;

  // Frame styles on the audio port
  localparam logic [1:0] JUST_RIGHT = 2'h0;
  localparam logic [1:0] JUST_LEFT  = 2'h1;
  localparam logic [1:0] JUST_I2S   = 2'h2;

  // ==========================================================
  // Timing: one gain step every 20 us
  localparam int STEP_TIME_NS = 20000;
  localparam int CLK_NS       = 8;
  localparam int STEP_CYCLES  = STEP_TIME_NS / CLK_NS;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [6:0]  page;
    logic [5:0]  addr;
    logic        write;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [1:0] highpass_corner_sel;
    logic [1:0] left_record_source;
    logic [1:0] right_record_source;
    logic [4:0] mic_preamp_gain_db;
    logic [9:0] mclk_ratio;
    logic [3:0] sample_rate_code;
    logic       rate_code_valid;
    logic [4:0] play_word_bits;
    logic [1:0] play_justify;
    logic [4:0] rec_word_bits;
    logic [1:0] rec_justify;
  } path_cfg_s;

  typedef struct packed {
    logic [6:0] gain;
    logic       tie_to_common_mode;
    logic       stepping;
  } chan_out_s;

endpackage : codec_cfg_pkg

// file: record_gain_stepper.sv
`timescale 1ns/1ps
module record_gain_stepper
  import codec_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic      i_clk_sys,
  input  wire logic      i_rst,
  // Control
  input  wire logic      i_step_tick,
  input  wire logic      i_mute,
  input  wire logic [6:0] i_target,
  // Applied state
  output chan_out_s      o_chan
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [6:0] gain;
    logic       muted;
  } step_state_s;

  step_state_s state_q;
  step_state_s state_d;
  logic        want_mute;

  always_comb begin
    state_d   = state_q;
    want_mute = i_mute || (i_target < GAIN_FLOOR);
    if (want_mute) begin
      // Ramp to the floor first, only then cut the input
      if (state_q.gain > GAIN_FLOOR) begin
        if (i_step_tick) begin
          state_d.gain = state_q.gain - 7'h01;
        end
      end else begin
        state_d.gain  = GAIN_FLOOR;
        state_d.muted = 1'b1;
      end
    end else if (state_q.muted) begin
      // Release from the floor, then climb back
      state_d.muted = 1'b0;
      state_d.gain  = GAIN_FLOOR;
    end else if (i_step_tick) begin
      // Never jump: one code per tick toward the target
      if (state_q.gain < i_target) begin
        state_d.gain = state_q.gain + 7'h01;
      end else if (state_q.gain > i_target) begin
        state_d.gain = state_q.gain - 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= '{gain: GAIN_FLOOR, muted: 1'b1};
    end else begin
      state_q <= state_d;
    end
  end

  // A pending mute counts as stepping until the input is actually tied
  assign o_chan = '{gain:               state_q.gain,
                    tie_to_common_mode: state_q.muted,
                    stepping:           state_q.muted ? !want_mute
                                                      : (want_mute || state_q.gain != i_target)};

endmodule : record_gain_stepper

// file: codec_audio_config_regs.sv
`timescale 1ns/1ps
//
// Contract
// - Control word at page 2 address 00h, sixteen bits, read and write.
// - Bits 15:14 pick high-pass corner; 11 at reset.
// - Bits 13:12 pick left record source; microphone at reset.
// - Bits 11:10 pick right record source, same coding; microphone at reset.
// - Bits 9:8 mic gain: 00/01 0 dB, 10 6 dB, 11 12 dB.
// - Bits 7:6 clock ratio: 00/11 256, 01 384, 10 512.
// - Bits 5:2 sample rate code, nine codes, 48k at reset.
// - Format 00: playback 16-bit right justified, record 16-bit left justified.
// - Format 01: playback 20-bit right justified, record 20-bit left justified.
// - Format 10: both directions 20-bit left justified.
// - Format 11 at reset: both directions 20-bit I2S.
// - Gain word at page 2 address 01h with mute and gain fields.
// - Gain spans -40 to +20 dB in half-dB codes.
// - Mute keeps stored gain; unmute returns to it.
// - Mute ramps down then mutes; unmute reverses the ramp.
// - Muted channel input is tied to common mode.
// - 7Fh +20 dB, 57h 0 dB reset, 07h -40 dB, below mutes.
// - Both mute bits set at reset.
// - Gain changes are single-stepped, never jumped.
module codec_audio_config_regs
  import codec_cfg_pkg::*;
#(
  parameter int STEP_TICK_CYCLES = STEP_CYCLES
)(
  // Clock and reset
  input  wire logic   i_clk_sys,
  input  wire logic   i_rst,
  // Register access from the serial control port
  input  wire logic   i_req_valid,
  input  reg_req_s    i_req,
  output logic        o_req_hit,
  output logic [15:0] o_rdata,
  // Decoded record path and audio port setup
  output path_cfg_s   o_path_cfg,
  // Applied record gains
  output chan_out_s   o_left_chan,
  output chan_out_s   o_right_chan
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] path_ctrl;
    logic [15:0] rec_gain;
    logic [15:0] rdata;
    logic [15:0] tick_cnt;
    logic        tick;
    path_cfg_s   cfg;
  } regs_state_s;

  localparam logic [15:0] TICK_LAST = 16'(STEP_TICK_CYCLES - 1);

  regs_state_s state_q;
  regs_state_s state_d;
  logic        sel_ctrl;
  logic        sel_gain;
  logic [1:0]  fmt;
  logic [1:0]  mic_code;
  logic [1:0]  ratio;

  assign sel_ctrl  = i_req.page == PAGE_AUDIO && i_req.addr == ADDR_PATH_CTRL;
  assign sel_gain  = i_req.page == PAGE_AUDIO && i_req.addr == ADDR_RECORD_GAIN;
  assign o_req_hit = i_req_valid && (sel_ctrl || sel_gain);

  // ==========================================================
  // Register file and decode
  always_comb begin
    state_d = state_q;
    // Writes arrive already deserialised from the serial control port
    if (i_req_valid && i_req.write) begin
      if (sel_ctrl) begin
        state_d.path_ctrl = i_req.wdata;
      end
      if (sel_gain) begin
        state_d.rec_gain = i_req.wdata;
      end
    end
    // Reads show stored words; the ramp lives elsewhere
    if (i_req_valid && !i_req.write) begin
      if (sel_ctrl) begin
        state_d.rdata = state_q.path_ctrl;
      end else if (sel_gain) begin
        state_d.rdata = state_q.rec_gain;
      end else begin
        state_d.rdata = 16'h0000;
      end
    end

    // Free running step tick, period set by parameter
    state_d.tick = 1'b0;
    if (state_q.tick_cnt >= TICK_LAST) begin
      state_d.tick_cnt = 16'h0000;
      state_d.tick     = 1'b1;
    end else begin
      state_d.tick_cnt = state_q.tick_cnt + 16'h0001;
    end

    fmt   = state_q.path_ctrl[FMT_LSB +: 2];
    mic_code = state_q.path_ctrl[MIC_GAIN_LSB +: 2];
    ratio = state_q.path_ctrl[MCLK_LSB +: 2];
    state_d.cfg.highpass_corner_sel = state_q.path_ctrl[HIPASS_LSB +: 2];
    state_d.cfg.left_record_source  = state_q.path_ctrl[LSRC_LSB +: 2];
    state_d.cfg.right_record_source = state_q.path_ctrl[RSRC_LSB +: 2];
    state_d.cfg.sample_rate_code    = state_q.path_ctrl[RATE_LSB +: 4];
    // Invalid codes are flagged, not corrected; the host must avoid them
    state_d.cfg.rate_code_valid     = state_q.path_ctrl[RATE_LSB +: 4] <= RATE_LAST;

    case (mic_code)
      MIC_GAIN_0DB_A: state_d.cfg.mic_preamp_gain_db = 5'h00;
      MIC_GAIN_0DB_B: state_d.cfg.mic_preamp_gain_db = 5'h00;
      MIC_GAIN_6DB:   state_d.cfg.mic_preamp_gain_db = 5'h06;
      MIC_GAIN_12DB:  state_d.cfg.mic_preamp_gain_db = 5'h0C;
      default:        state_d.cfg.mic_preamp_gain_db = 5'h00;
    endcase

    case (ratio)
      MCLK_384: state_d.cfg.mclk_ratio = 10'h180;
      MCLK_512: state_d.cfg.mclk_ratio = 10'h200;
      default:  state_d.cfg.mclk_ratio = 10'h100;
    endcase

    case (fmt)
      FMT_16_RJ: begin
        state_d.cfg.play_word_bits = 5'h10;
        state_d.cfg.play_justify   = JUST_RIGHT;
        state_d.cfg.rec_word_bits  = 5'h10;
        state_d.cfg.rec_justify    = JUST_LEFT;
      end
      FMT_20_RJ: begin
        state_d.cfg.play_word_bits = 5'h14;
        state_d.cfg.play_justify   = JUST_RIGHT;
        state_d.cfg.rec_word_bits  = 5'h14;
        state_d.cfg.rec_justify    = JUST_LEFT;
      end
      FMT_20_LJ: begin
        state_d.cfg.play_word_bits = 5'h14;
        state_d.cfg.play_justify   = JUST_LEFT;
        state_d.cfg.rec_word_bits  = 5'h14;
        state_d.cfg.rec_justify    = JUST_LEFT;
      end
      default: begin
        state_d.cfg.play_word_bits = 5'h14;
        state_d.cfg.play_justify   = JUST_I2S;
        state_d.cfg.rec_word_bits  = 5'h14;
        state_d.cfg.rec_justify    = JUST_I2S;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q           <= '0;
      state_q.path_ctrl <= PATH_CTRL_RESET;
      state_q.rec_gain  <= RECORD_GAIN_RESET;
      state_q.cfg.highpass_corner_sel <= PATH_CTRL_RESET[HIPASS_LSB +: 2];
      state_q.cfg.rate_code_valid     <= 1'b1;
      state_q.cfg.mclk_ratio          <= 10'h100;
      state_q.cfg.play_word_bits      <= 5'h14;
      state_q.cfg.play_justify        <= JUST_I2S;
      state_q.cfg.rec_word_bits       <= 5'h14;
      state_q.cfg.rec_justify         <= JUST_I2S;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rdata    = state_q.rdata;
  assign o_path_cfg = state_q.cfg;

  // ==========================================================
  // Soft-stepped record gain, -40..+20 dB in half-dB codes
  record_gain_stepper u_left (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_step_tick (state_q.tick),
    .i_mute      (state_q.rec_gain[LMUTE_BIT]),
    .i_target    (state_q.rec_gain[LGAIN_LSB +: 7]),
    .o_chan      (o_left_chan)
  );

  record_gain_stepper u_right (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_step_tick (state_q.tick),
    .i_mute      (state_q.rec_gain[RMUTE_BIT]),
    .i_target    (state_q.rec_gain[RGAIN_LSB +: 7]),
    .o_chan      (o_right_chan)
  );

endmodule : codec_audio_config_regs

// file: codec_cfg_checker.sv
`timescale 1ns/1ps
module codec_cfg_checker
  import codec_cfg_pkg::*;
#(
  parameter int STEP_TICK_CYCLES = 4
)(
  // Watched ports
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_req_valid,
  input wire reg_req_s    i_req,
  input wire logic        o_req_hit,
  input wire logic [15:0] o_rdata,
  input wire path_cfg_s   o_path_cfg,
  input wire chan_out_s   o_left_chan,
  input wire chan_out_s   o_right_chan
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ====
  // Register port
  AST_HIT: assert property (o_req_hit == (i_req_valid && i_req.page == PAGE_AUDIO
    && i_req.addr <= ADDR_RECORD_GAIN)) else $error("hit decode wrong");
  AST_UNMAPPED_READ: assert property (i_req_valid && !i_req.write && !o_req_hit
    |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
  AST_MIC_GAIN: assert property (o_path_cfg.mic_preamp_gain_db
    inside {5'h00, 5'h06, 5'h0C}) else $error("mic gain illegal");
  AST_RATE_OK: assert property (o_path_cfg.rate_code_valid ==
    (o_path_cfg.sample_rate_code <= RATE_LAST)) else $error("rate valid wrong");
  // ====
  // Gain ramp; the gap of three assumes a tick every four cycles
  AST_ONE_STEP: assert property (!$stable(o_left_chan.gain) |->
    (o_left_chan.gain - $past(o_left_chan.gain)) inside {7'h01, 7'h7F})
    else $error("gain jumped");
  AST_TICK_GAP: assert property ($changed(o_right_chan.gain) |=>
    $stable(o_right_chan.gain)[*3]) else $error("step faster than tick");
  AST_TIE_AT_FLOOR: assert property (o_left_chan.tie_to_common_mode |->
    o_left_chan.gain == GAIN_FLOOR) else $error("tied above floor");
  AST_NEVER_BELOW: assert property (o_right_chan.gain >= GAIN_FLOOR)
    else $error("gain below floor");
  AST_MUTE_AFTER_RAMP: assert property ($rose(o_left_chan.tie_to_common_mode) |->
    $past(o_left_chan.gain) == GAIN_FLOOR) else $error("muted before ramp end");
  cover property ($rose(o_left_chan.tie_to_common_mode));
  cover property ($fell(o_right_chan.tie_to_common_mode));
  cover property (i_req_valid && i_req.write && o_req_hit);
  cover property ($fell(o_left_chan.stepping));
endmodule : codec_cfg_checker

// file: host_model.sv
`timescale 1ns/1ps
module host_model
  import codec_cfg_pkg::*;
(
  // Clock and read data
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_rdata,
  // Request
  output logic             o_req_valid,
  output reg_req_s         o_req
);
  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
  end
  // One whole word per request, held for its taking edge only
  task automatic access(input logic [6:0] pg, input logic [5:0] ad,
                        input logic wr, input logic [15:0] wd,
                        output logic [15:0] rd);
    @(negedge i_clk_sys);
    o_req_valid = 1'b1;
    o_req = '{pg, ad, wr, wd};
    @(negedge i_clk_sys);
    o_req_valid = 1'b0;
    // Stale fields are inverted so a late sample cannot look right
    o_req = ~o_req;
    @(negedge i_clk_sys);
    rd = i_rdata;
  endtask : access
endmodule : host_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import codec_cfg_pkg::*;
  localparam int STEP_TICK_CYCLES = 4;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_req_valid;
  reg_req_s    i_req;
  logic        o_req_hit;
  logic [15:0] o_rdata;
  path_cfg_s   o_path_cfg;
  chan_out_s   o_left_chan;
  chan_out_s   o_right_chan;
  int          mismatches = 0;
  int          check_count = 0;
  int          seed = 49062;
  logic [15:0] rd;
  logic [15:0] w;

  always #4 i_clk_sys = ~i_clk_sys;

  codec_audio_config_regs #(.STEP_TICK_CYCLES(STEP_TICK_CYCLES)) codec_audio_config_regs_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
    .o_req_hit(o_req_hit), .o_rdata(o_rdata), .o_path_cfg(o_path_cfg),
    .o_left_chan(o_left_chan), .o_right_chan(o_right_chan));
  host_model host_model_i (
    .i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .o_req_valid(i_req_valid), .o_req(i_req));

  // ====
  // Expectations and compares
  function automatic path_cfg_s exp_cfg(logic [15:0] v);
    path_cfg_s c;
    c.highpass_corner_sel = v[15:14];
    c.left_record_source = v[13:12];
    c.right_record_source = v[11:10];
    c.mic_preamp_gain_db = (v[9:8] == 2'h2) ? 5'h06 : (v[9:8] == 2'h3) ? 5'h0C : 5'h00;
    c.mclk_ratio = (v[7:6] == 2'h1) ? 10'h180 : (v[7:6] == 2'h2) ? 10'h200 : 10'h100;
    c.sample_rate_code = v[5:2];
    c.rate_code_valid = (v[5:2] <= 4'h8);
    c.play_word_bits = (v[1:0] == 2'h0) ? 5'h10 : 5'h14;
    c.rec_word_bits = c.play_word_bits;
    c.play_justify = (v[1:0] == 2'h3) ? JUST_I2S : v[1] ? JUST_LEFT : JUST_RIGHT;
    c.rec_justify = (v[1:0] == 2'h3) ? JUST_I2S : JUST_LEFT;
    return c;
  endfunction : exp_cfg

  task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk16

  task automatic chk_cfg(path_cfg_s e);
    check_count++;
    if (o_path_cfg !== e) begin
      mismatches++;
      $display("unexpected cfg exp %h got %h", e, o_path_cfg);
    end
  endtask : chk_cfg

  task automatic chk_ch(bit r, logic [6:0] g, logic t);
    chan_out_s c;
    c = r ? o_right_chan : o_left_chan;
    check_count++;
    // A settled channel must no longer report stepping
    if ({c.gain, c.tie_to_common_mode, c.stepping} !== {g, t, 1'b0}) begin
      mismatches++;
      $display("unexpected chan%0d exp %h/%b/0 got %h/%b/%b", r, g, t, c.gain,
               c.tie_to_common_mode, c.stepping);
    end
  endtask : chk_ch

  task automatic wait_ch(bit r, logic [6:0] g, logic t);
    chan_out_s c;
    int i;
    for (i = 0; i < 1000; i++) begin
      c = r ? o_right_chan : o_left_chan;
      if (c.gain === g && c.tie_to_common_mode === t) break;
      @(negedge i_clk_sys);
    end
    chk_ch(r, g, t);
    if (i == 1000) conclude();
  endtask : wait_ch

  task automatic wr(logic [5:0] a, logic [15:0] d);
    host_model_i.access(PAGE_AUDIO, a, 1'b1, d, rd);
  endtask : wr

  task automatic rdr(logic [6:0] p, logic [5:0] a);
    host_model_i.access(p, a, 1'b0, 16'h0000, rd);
  endtask : rdr

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // ====
  // Main sequence
  initial begin
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    rdr(PAGE_AUDIO, ADDR_PATH_CTRL);
    chk16("ctrl", 16'hC003, rd);
    chk_cfg(exp_cfg(16'hC003));
    rdr(PAGE_AUDIO, ADDR_RECORD_GAIN);
    chk16("gain", 16'hD7D7, rd);
    chk_ch(0, 7'h07, 1'b1);
    chk_ch(1, 7'h07, 1'b1);
    $display("test reset done");
    // Every legal rate code is visited; the host never writes the others
    for (int i = 0; i < 12; i++) begin
      w = 16'($random(seed));
      w[9:6] = {i[1:0], ~i[1:0]};
      w[5:2] = 4'(i % 9);
      w[1:0] = i[1:0];
      wr(ADDR_PATH_CTRL, w);
      rdr(PAGE_AUDIO, ADDR_PATH_CTRL);
      chk16("ctrl", w, rd);
      chk_cfg(exp_cfg(w));
    end
    $display("test control word done");
    wr(6'h02, 16'hFFFF);
    host_model_i.access(7'h03, ADDR_PATH_CTRL, 1'b1, 16'h0000, rd);
    rdr(PAGE_AUDIO, 6'h02);
    chk16("unmapped", 16'h0000, rd);
    rdr(PAGE_AUDIO, ADDR_PATH_CTRL);
    chk16("ctrl kept", w, rd);
    $display("test unmapped done");
    wr(ADDR_RECORD_GAIN, 16'h0AD7);
    wait_ch(0, 7'h0A, 1'b0);
    chk_ch(1, 7'h07, 1'b1);
    rdr(PAGE_AUDIO, ADDR_RECORD_GAIN);
    chk16("gain", 16'h0AD7, rd);
    wr(ADDR_RECORD_GAIN, 16'h8AD7);
    wait_ch(0, 7'h07, 1'b1);
    rdr(PAGE_AUDIO, ADDR_RECORD_GAIN);
    chk16("gain", 16'h8AD7, rd);
    wr(ADDR_RECORD_GAIN, 16'h0A57);
    wait_ch(0, 7'h0A, 1'b0);
    wait_ch(1, 7'h57, 1'b0);
    wr(ADDR_RECORD_GAIN, 16'h0357);
    wait_ch(0, 7'h07, 1'b1);
    wr(ADDR_RECORD_GAIN, 16'h7F57);
    wait_ch(0, 7'h7F, 1'b0);
    $display("test gain ramp done");
    conclude();
  end
endmodule : testbench

bind codec_audio_config_regs codec_cfg_checker #(.STEP_TICK_CYCLES(STEP_TICK_CYCLES)) chk_i (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
  .o_req_hit(o_req_hit), .o_rdata(o_rdata), .o_path_cfg(o_path_cfg),
  .o_left_chan(o_left_chan), .o_right_chan(o_right_chan));
